// ===== rtl/apg_pkg.sv
// Constants, types and the shared trim function of the automatic PWM generator.
// Function
// - Prescaler 00 means normal mode; output follows its input pin combined with its output-enable bit.
// - Autonomous PWM runs only while the start bit is set.
// - Setting start in stand-by wakes the device; PWM waits for wake delay.
// - Clock select bit 5: 0 external clock pin, 1 internal oscillator.
// - PWM period is the time base divided by 256, doubled for each prescaler step above 01.
// - Prescaler 01, 10, 11 divide the time base by 256, 512, 1024.
// - Diagnosis bit 11 is 1 when external clock is slow; invalid in stand-by.
// - Clock-error flag clears after a diagnosis readout, only when set.
// - Trim bits 8:6 step oscillator frequency; 100 nominal, 000 is minus four.
// - Changing the trim also shifts the external clock monitor threshold.
// - On-time per period is duty value over 256, duty spans 0 to 256.
// - Eight channel phase shifts, counted from one common period start.
// - Device phase field offsets all timing of this device.
// - After start is set, PWM begins at the next time-base rising edge.
// - Lamp bits of channels 2 and 3: 0 bulb mode, 1 LED mode.
// - Compat bit 0 repurposes driver outputs as diagnosis enable and select.
// - Combination bit 3 joins input pin and enable bit by OR or AND.
// - Each channel phase step is 32 time-base cycles, up to 224.
// - Duty with top bit set is fully on; zero is fully off.
// - Single-duty bit 3, when clear, applies channel 0 duty to every channel.
package apg_pkg;

   localparam int unsigned CORE_HZ       = 25_000_000;
   localparam int unsigned INT_OSC_HZ    = 105_000;
   localparam int unsigned CLK_MON_HZ    = 34_000;
   localparam int unsigned TRIM_STEP_PCT = 5;
   localparam int unsigned WAKE_US       = 200;
   localparam int unsigned NUM_CH        = 6;

   localparam logic [10:0] INT_DIV       = 11'(CORE_HZ / INT_OSC_HZ);
   localparam logic [10:0] INT_TRIM_STEP = 11'(CORE_HZ / INT_OSC_HZ * TRIM_STEP_PCT / 100);
   localparam logic [10:0] MON_DIV       = 11'(CORE_HZ / CLK_MON_HZ);
   localparam logic [10:0] MON_TRIM_STEP = 11'(CORE_HZ / CLK_MON_HZ * TRIM_STEP_PCT / 100);
   localparam logic [10:0] TRIM_NOM_MUL  = 11'h004;

   // Register indices: read/write bit stripped, {bank bit, 4-bit address}.
   localparam logic [4:0] ADDR_OUT  = 5'h00;
   localparam logic [4:0] ADDR_PCR  = 5'h07;
   localparam logic [4:0] ADDR_DCCR = 5'h08;
   localparam logic [4:0] ADDR_INPUT_AND_DRIVER_CONFIG = 5'h11;
   localparam logic [4:0] ADDR_HARDWARE_CONFIG = 5'h12;
   localparam logic [4:0] ADDR_CHCR = 5'h18;

   localparam int unsigned FR_WRITE   = 15;
   localparam int unsigned FR_ADDR_LO = 10;
   localparam int unsigned PCR_PST    = 0;
   localparam int unsigned PCR_DEVICE_PHASE_FIELD   = 1;
   localparam int unsigned PCR_DCS    = 3;
   localparam int unsigned IE_COMPAT  = 0;
   localparam int unsigned IE_DRIVE   = 2;
   localparam int unsigned IE_COMB    = 3;
   localparam int unsigned HW_LED     = 2;
   localparam int unsigned HW_CLK     = 5;
   localparam int unsigned HW_TRIM    = 6;
   localparam int unsigned DIAG_CLE   = 11;

   localparam logic [2:0] TRIM_RESET = 3'h4;
   localparam logic [5:0] CNT_LAST   = 6'h3F;

   typedef struct packed {
      logic [2:0] phase;
      logic [1:0] sync_delay;
      logic [1:0] freq;
   } apg_chan_cfg_type;

   typedef struct packed {
      logic [2:0] trim;
      logic       clk_internal;
      logic [1:0] led_mode;
   } apg_hw_cfg_type;

   typedef enum logic [4:0] {
      ST_STANDBY = 5'h01,
      ST_WAKING  = 5'h02,
      ST_IDLE    = 5'h04,
      ST_ARMED   = 5'h08,
      ST_RUN     = 5'h10
   } apg_state_type;

   // Higher trim means a faster clock, so the cycle count shrinks.
   function automatic logic [10:0] apg_trim_scale(input logic [10:0] base,
                                                  input logic [10:0] step,
                                                  input logic [2:0]  trim);
      logic [10:0] mul;
      mul = {8'h00, trim};
      return 11'(base + step * TRIM_NOM_MUL - step * mul);
   endfunction : apg_trim_scale

endpackage : apg_pkg

// ===== rtl/apg_timebase.sv
// PWM time-base source selection, internal oscillator and external clock monitor.
`timescale 1ns/10ps
`default_nettype none
module apg_timebase
   import apg_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       pclk_pin,
   input  wire logic       clk_internal,
   input  wire logic [2:0] trim,
   output logic            tick,
   output logic            pclk_slow
);

   logic        pclk_prev_reg;
   logic [10:0] osc_cnt_reg;
   logic [10:0] gap_cnt_reg;

   wire         pclk_rise = pclk_pin & ~pclk_prev_reg;
   wire  [10:0] osc_div   = apg_trim_scale(INT_DIV, INT_TRIM_STEP, trim);
   wire  [10:0] mon_lim   = apg_trim_scale(MON_DIV, MON_TRIM_STEP, trim);
   wire         osc_wrap  = (osc_cnt_reg >= 11'(osc_div - 11'h001));
   wire         gap_full  = (gap_cnt_reg >= mon_lim);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pclk_prev_reg <= 1'b0;
         osc_cnt_reg   <= 11'h000;
         gap_cnt_reg   <= 11'h000;
      end else begin
         pclk_prev_reg <= pclk_pin;
         osc_cnt_reg   <= osc_wrap ? 11'h000 : 11'(osc_cnt_reg + 11'h001);
         gap_cnt_reg   <= pclk_rise ? 11'h000 : (gap_full ? gap_cnt_reg : 11'(gap_cnt_reg + 11'h001));
      end
   end

   assign tick      = clk_internal ? osc_wrap : pclk_rise;
   assign pclk_slow = gap_full;

endmodule : apg_timebase
`default_nettype wire

// ===== rtl/apg_channel.sv
// One channel's PWM comparator: prescaler, phase shift and duty compare.
`timescale 1ns/10ps
`default_nettype none
module apg_channel
   import apg_pkg::*;
(
   input  wire logic [9:0]       base_cnt,
   input  wire apg_chan_cfg_type cfg,
   input  wire logic [8:0]       duty,
   output logic                  pwm
);

   wire [9:0] local_cnt = 10'(base_cnt - {2'h0, cfg.phase, 5'h00});
   wire [7:0] step_idx  = (cfg.freq == 2'h1) ? local_cnt[7:0] :
                          (cfg.freq == 2'h2) ? local_cnt[8:1] : local_cnt[9:2];

   assign pwm = duty[8] | (step_idx < duty[7:0]);

endmodule : apg_channel
`default_nettype wire

// ===== rtl/apg_top.sv
// Serial-configured automatic PWM generator with diagnosis word and channel outputs.
`timescale 1ns/10ps
`default_nettype none
module apg_top
   import apg_pkg::*;
#(
   parameter int unsigned WAKE_CYCLES = WAKE_US * (CORE_HZ / 1_000_000)
)
(
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_n,
   input  wire logic        spi_sdi,
   output logic             spi_sdo,
   input  wire logic        pclk_pin,
   input  wire logic [5:0]  in_pin,
   output logic [5:0]       channel_on,
   output logic [1:0]       lamp_type_bit,
   output logic             input_drive_bit,
   output logic             ext_driver_diag_out0,
   output logic             ext_driver_diag_out1,
   output logic             standby_out
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************

   logic                   sclk_prev_reg;
   logic                   cs_prev_reg;
   logic [15:0]            shift_reg;
   logic [5:0]             bit_cnt_reg;
   logic                   sdo_reg;
   logic                   diag_sent_reg;
   logic                   read_req_reg;
   logic [4:0]             read_idx_reg;

   logic [5:0]             out_reg;
   logic [3:0]             pcr_reg;
   logic [3:0]             input_and_driver_config_reg;
   apg_hw_cfg_type         hw_reg;
   logic [8:0]             duty_reg  [NUM_CH];
   apg_chan_cfg_type       chcfg_reg [NUM_CH];

   apg_state_type          state_reg;
   apg_state_type          state_next;
   logic [12:0]            wake_cnt_reg;
   logic [9:0]             base_cnt_reg;
   logic                   dev_ok_reg;
   logic                   cle_reg;

   logic [5:0]             chan_reg;
   logic                   ext_driver_diag_out0_reg;
   logic                   ext_driver_diag_out1_reg;

   logic                   tick;
   logic                   pclk_slow;
   logic [5:0]             pwm;
   logic [5:0]             chan_next;

   // ****************************************************************
   // Register index decoding.
   // ****************************************************************

   // A channel bank index: same upper bits and a channel number in range.
   function automatic logic is_chan(input logic [4:0] idx, input logic [4:0] bank);
      return (idx[4:3] == bank[4:3]) && (idx[2:0] < 3'(NUM_CH));
   endfunction : is_chan

   // ****************************************************************
   // Serial port sampling.
   // ****************************************************************

   wire        cs_fall    = cs_prev_reg & ~spi_cs_n;
   wire        cs_rise    = ~cs_prev_reg & spi_cs_n;
   wire        sclk_rise  = ~spi_cs_n & spi_sclk & ~sclk_prev_reg;
   wire        sclk_fall  = ~spi_cs_n & ~spi_sclk & sclk_prev_reg;
   wire        frame_ok   = cs_rise && (bit_cnt_reg != 6'h00) && (bit_cnt_reg[3:0] == 4'h0);

   wire        wr_en      = frame_ok & shift_reg[FR_WRITE];
   wire [4:0]  wr_idx     = shift_reg[FR_WRITE-1:FR_ADDR_LO];
   wire [9:0]  wr_data    = shift_reg[9:0];
   wire [2:0]  wr_ch      = wr_idx[2:0];
   wire [2:0]  rd_ch      = read_idx_reg[2:0];

   wire        awake      = (state_reg == ST_IDLE) || (state_reg == ST_ARMED) ||
                            (state_reg == ST_RUN);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sclk_prev_reg <= 1'b0;
         cs_prev_reg   <= 1'b1;
      end else begin
         sclk_prev_reg <= spi_sclk;
         cs_prev_reg   <= spi_cs_n;
      end
   end

   // ****************************************************************
   // Answer words.
   // ****************************************************************

   wire [15:0] diag_word  = {4'h0, cle_reg, 11'h000};

   wire [9:0]  hw_read    = {1'b0, hw_reg.trim, hw_reg.clk_internal, 1'b0,
                             hw_reg.led_mode, ~awake, 1'b0};

   wire [9:0]  rd_data    =
      (read_idx_reg == ADDR_OUT)        ? {4'h0, out_reg}             :
      (read_idx_reg == ADDR_PCR)        ? {6'h00, pcr_reg}            :
      (read_idx_reg == ADDR_INPUT_AND_DRIVER_CONFIG)       ? {6'h00, input_and_driver_config_reg}           :
      (read_idx_reg == ADDR_HARDWARE_CONFIG)       ? hw_read                     :
      is_chan(read_idx_reg, ADDR_DCCR)  ? {1'b0, duty_reg[rd_ch]}     :
      is_chan(read_idx_reg, ADDR_CHCR)  ? {3'h0, chcfg_reg[rd_ch]}    :
                                          10'h000;

   wire [15:0] answer     = read_req_reg ? {1'b0, read_idx_reg, rd_data} : diag_word;

   // ****************************************************************
   // Serial shift register.
   // ****************************************************************

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         shift_reg     <= 16'h0000;
         bit_cnt_reg   <= 6'h00;
         sdo_reg       <= 1'b0;
         diag_sent_reg <= 1'b0;
      end else if (cs_fall) begin
         shift_reg     <= answer;
         bit_cnt_reg   <= 6'h00;
         sdo_reg       <= answer[15];
         diag_sent_reg <= ~read_req_reg;
      end else if (sclk_rise) begin
         shift_reg     <= {shift_reg[14:0], spi_sdi};
         bit_cnt_reg   <= 6'(bit_cnt_reg + 6'h01);
      end else if (sclk_fall) begin
         sdo_reg       <= shift_reg[15];
      end
   end

   // A read request turns the next answer into that register's content.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         read_req_reg <= 1'b0;
         read_idx_reg <= 5'h00;
      end else if (frame_ok) begin
         read_req_reg <= ~shift_reg[FR_WRITE];
         read_idx_reg <= wr_idx;
      end
   end

   // ****************************************************************
   // Configuration registers.
   // ****************************************************************

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_reg  <= 6'h00;
         pcr_reg  <= 4'h0;
         input_and_driver_config_reg <= 4'h0;
         hw_reg   <= '{trim: TRIM_RESET, clk_internal: 1'b0, led_mode: 2'h0};
      end else if (wr_en) begin
         if (wr_idx == ADDR_OUT) begin
            out_reg <= wr_data[5:0];
         end
         if (wr_idx == ADDR_PCR) begin
            pcr_reg <= wr_data[3:0];
         end
         if (wr_idx == ADDR_INPUT_AND_DRIVER_CONFIG) begin
            input_and_driver_config_reg <= wr_data[3:0];
         end
         if (wr_idx == ADDR_HARDWARE_CONFIG) begin
            hw_reg.trim         <= wr_data[HW_TRIM+2:HW_TRIM];
            hw_reg.clk_internal <= wr_data[HW_CLK];
            hw_reg.led_mode     <= wr_data[HW_LED+1:HW_LED];
         end
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_chan_regs
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               duty_reg[gi]  <= 9'h000;
               chcfg_reg[gi] <= '0;
            end else if (wr_en && (wr_ch == 3'(gi))) begin
               if (is_chan(wr_idx, ADDR_DCCR)) begin
                  duty_reg[gi] <= wr_data[8:0];
               end
               if (is_chan(wr_idx, ADDR_CHCR)) begin
                  chcfg_reg[gi] <= wr_data[6:0];
               end
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Time base and clock monitor.
   // ****************************************************************

   apg_timebase u_timebase (
      .core_clk     (core_clk),
      .rst          (rst),
      .pclk_pin     (pclk_pin),
      .clk_internal (hw_reg.clk_internal),
      .trim         (hw_reg.trim),
      .tick         (tick),
      .pclk_slow    (pclk_slow)
   );

   // A slow clock seen while awake sets the flag; a completed diagnosis
   // readout clears it, but a new detection in that cycle wins.
   wire cle_set   = pclk_slow & awake;
   wire cle_clear = frame_ok & diag_sent_reg & cle_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cle_reg <= 1'b0;
      end else begin
         cle_reg <= cle_set | (cle_reg & ~cle_clear);
      end
   end

   // ****************************************************************
   // Operating state.
   // ****************************************************************

   wire pwm_start_bit       = pcr_reg[PCR_PST];
   wire wake_done = (wake_cnt_reg >= 13'(WAKE_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STANDBY: begin
            if (pwm_start_bit) begin
               state_next = ST_WAKING;
            end
         end
         ST_WAKING: begin
            if (wake_done) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (pwm_start_bit) begin
               state_next = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (!pwm_start_bit) begin
               state_next = ST_IDLE;
            end else if (tick) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!pwm_start_bit) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg    <= ST_STANDBY;
         wake_cnt_reg <= 13'h0000;
      end else begin
         state_reg    <= state_next;
         wake_cnt_reg <= (state_reg == ST_WAKING) ? 13'(wake_cnt_reg + 13'h0001) : 13'h0000;
      end
   end

   // ****************************************************************
   // Common period counter with device phase offset.
   // ****************************************************************

   wire       running   = (state_reg == ST_RUN);
   wire [1:0] dev_phase = pcr_reg[PCR_DEVICE_PHASE_FIELD+1:PCR_DEVICE_PHASE_FIELD];
   wire [9:0] cnt_start = 10'(10'h000 - {5'h00, dev_phase, 3'h0});
   wire       cnt_wrap  = tick && (base_cnt_reg == {4'hF, CNT_LAST});
   wire       pwm_live  = running & (dev_ok_reg | (dev_phase == 2'h0));

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         base_cnt_reg <= 10'h000;
         dev_ok_reg   <= 1'b0;
      end else if (!running) begin
         base_cnt_reg <= cnt_start;
         dev_ok_reg   <= 1'b0;
      end else if (tick) begin
         base_cnt_reg <= 10'(base_cnt_reg + 10'h001);
         dev_ok_reg   <= dev_ok_reg | cnt_wrap;
      end
   end

   // ****************************************************************
   // Channel waveforms and output selection.
   // ****************************************************************

   wire       single_duty = ~pcr_reg[PCR_DCS];
   wire [5:0] comb_in     = input_and_driver_config_reg[IE_COMB] ? (in_pin & out_reg) : (in_pin | out_reg);

   generate
      for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
         wire [8:0] duty_sel = single_duty ? duty_reg[0] : duty_reg[gi];
         wire       normal   = (chcfg_reg[gi].freq == 2'h0);

         apg_channel u_channel (
            .base_cnt (base_cnt_reg),
            .cfg      (chcfg_reg[gi]),
            .duty     (duty_sel),
            .pwm      (pwm[gi])
         );

         assign chan_next[gi] = !awake ? 1'b0 :
                                normal ? comb_in[gi] :
                                (pwm_live & pwm[gi] & out_reg[gi]);
      end
   endgenerate

   // ****************************************************************
   // External driver control outputs.
   // ****************************************************************

   wire compat    = input_and_driver_config_reg[IE_COMPAT];
   wire ext_driver_diag_out0_next = compat ? (chan_next[4] | chan_next[5]) : chan_next[4];
   wire ext_driver_diag_out1_next = compat ? chan_next[5] : chan_next[5] & ~chan_next[4];

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         chan_reg <= 6'h00;
         ext_driver_diag_out0_reg <= 1'b0;
         ext_driver_diag_out1_reg <= 1'b0;
      end else begin
         chan_reg <= chan_next;
         ext_driver_diag_out0_reg <= ext_driver_diag_out0_next;
         ext_driver_diag_out1_reg <= ext_driver_diag_out1_next;
      end
   end

   // ****************************************************************
   // Outputs.
   // ****************************************************************

   assign spi_sdo              = sdo_reg;
   assign channel_on           = chan_reg;
   assign lamp_type_bit        = hw_reg.led_mode;
   assign input_drive_bit      = input_and_driver_config_reg[IE_DRIVE];
   assign ext_driver_diag_out0 = ext_driver_diag_out0_reg;
   assign ext_driver_diag_out1 = ext_driver_diag_out1_reg;
   assign standby_out          = state_reg[0];

endmodule : apg_top
`default_nettype wire

// ===== sim/apg_props.sv
// Port assertions for the automatic PWM generator.
`timescale 1ns/10ps
`default_nettype none
module apg_props
#(
   parameter int unsigned WAKE_CYCLES = 20
)
(
   input wire logic       core_clk,
   input wire logic       rst,
   input wire logic       spi_sclk,
   input wire logic       spi_cs_n,
   input wire logic       spi_sdi,
   input wire logic       spi_sdo,
   input wire logic       pclk_pin,
   input wire logic [5:0] in_pin,
   input wire logic [5:0] channel_on,
   input wire logic [1:0] lamp_type_bit,
   input wire logic       input_drive_bit,
   input wire logic       ext_driver_diag_out0,
   input wire logic       ext_driver_diag_out1,
   input wire logic       standby_out
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   sequence s_wake;
      $fell(standby_out);
   endsequence
   sequence s_dark;
      (channel_on == 6'h00) [*8];
   endsequence
   AST_ASLEEP_OFF: assert property (standby_out |-> channel_on == 6'h00)
      else $error("channel on in stand-by");
   AST_WAKE_DARK: assert property (s_wake |-> s_dark)
      else $error("channel on during wake delay");
   AST_WAKE_BY_FRAME: assert property (s_wake |-> spi_cs_n && $past(spi_cs_n))
      else $error("wake outside a finished frame");
   AST_STAY_AWAKE: assert property (!standby_out |=> !standby_out)
      else $error("return to stand-by");
   AST_LAMP_BY_FRAME: assert property ($changed(lamp_type_bit) |-> spi_cs_n && $past(spi_cs_n))
      else $error("lamp mode changed outside a frame end");
   AST_EXT_DRIVER_DIAG_OUT0_CH4: assert property (channel_on[4] && $past(channel_on[4]) |-> ext_driver_diag_out0)
      else $error("driver output 0 low with channel 4 on");
   AST_EXT_DRIVER_DIAG_OUT0_SRC: assert property (ext_driver_diag_out0 |-> |{channel_on[5:4], $past(channel_on[5:4])})
      else $error("driver output 0 high with both channels off");
   AST_EXT_DRIVER_DIAG_OUT1_CH5: assert property (ext_driver_diag_out1 |-> channel_on[5] || $past(channel_on[5]))
      else $error("driver output 1 high with channel 5 off");
endmodule : apg_props
`default_nettype wire

// ===== sim/apg_host.sv
// Host controller model that sends 16-bit serial frames to the generator.
`timescale 1ns/10ps
`default_nettype none
module apg_host
(
   input  wire logic core_clk,
   output logic      spi_sclk,
   output logic      spi_cs_n,
   output logic      spi_sdi,
   input  wire logic spi_sdo
);
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_sdi  = 1'b1;
   end
   // One frame at 2.5 MHz, MSB first; the data line shows the inverse of its last bit afterwards.
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      @(negedge core_clk);
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (2) @(negedge core_clk);
         spi_sdi = w[i];
         repeat (3) @(negedge core_clk);
         spi_sclk = 1'b1;
         r[i] = spi_sdo;
         repeat (5) @(negedge core_clk);
         spi_sclk = 1'b0;
      end
      repeat (3) @(negedge core_clk);
      spi_cs_n = 1'b1;
      spi_sdi = ~spi_sdi;
      repeat (4) @(negedge core_clk);
   endtask : xfer
endmodule : apg_host
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the automatic PWM generator.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import apg_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        pclk_pin = 1'b0;
   logic        pclk_en  = 1'b0;
   logic [5:0]  in_pin   = 6'h00;
   logic [5:0]  ch_q     = 6'h00;
   logic [31:0] seed     = 32'h8B6810C9;
   logic [15:0] resp;
   logic [8:0]  dt [6];
   logic [1:0]  fq [6]   = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
   int          failures, n_compared, tick_no, on_cnt [6], rise_at [6], per [6];
   wire  [5:0]  channel_on;
   wire  [1:0]  lamp_type_bit;
   wire         spi_sclk, spi_cs_n, spi_sdi, spi_sdo, input_drive_bit;
   wire         ext_driver_diag_out0, ext_driver_diag_out1, standby_out;
   apg_top #(.WAKE_CYCLES(20)) i_apg_top (.core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
      .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .pclk_pin(pclk_pin),
      .in_pin(in_pin), .channel_on(channel_on), .lamp_type_bit(lamp_type_bit),
      .input_drive_bit(input_drive_bit), .ext_driver_diag_out0(ext_driver_diag_out0),
      .ext_driver_diag_out1(ext_driver_diag_out1), .standby_out(standby_out));
   apg_host i_apg_host (.core_clk(core_clk), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
      .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
   always #20 core_clk = ~core_clk;
   always begin
      repeat (5) @(negedge core_clk);
      pclk_pin <= pclk_pin ^ pclk_en;
   end
   always @(negedge pclk_pin) begin
      tick_no++;
      for (int k = 0; k < 6; k++) on_cnt[k] += int'(channel_on[k]);
   end
   always @(posedge core_clk) begin
      ch_q <= channel_on;
      for (int k = 0; k < 6; k++) begin
         if (channel_on[k] === 1'b1 && ch_q[k] === 1'b0) begin
            per[k] = tick_no - rise_at[k];
            rise_at[k] = tick_no;
         end
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic int eff(input logic [8:0] d);
      return d[8] ? 256 : int'(d[7:0]);
   endfunction : eff
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [4:0] a, input logic [9:0] d);
      i_apg_host.xfer({1'b1, a, d}, resp);
   endtask : wr
   // A read is answered during the following frame.
   task automatic rd(input logic [4:0] a, output logic [15:0] r);
      i_apg_host.xfer({1'b0, a, 10'h000}, resp);
      i_apg_host.xfer({1'b0, a, 10'h000}, r);
   endtask : rd
   task automatic wait_ticks(input int n);
      repeat (n) @(negedge pclk_pin);
   endtask : wait_ticks
   task automatic end_sim();
      if (failures == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   initial begin
      #3_000_000;
      failures++;
      end_sim();
   end
   initial begin
      logic [31:0] v;
      logic [15:0] r;
      logic [5:0]  e;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      check({9'h000, standby_out, channel_on}, 16'h0040);
      rd(ADDR_HARDWARE_CONFIG, r);
      check(r, {1'b0, ADDR_HARDWARE_CONFIG, 10'h102});
      rd(5'h1F, r);
      check(r, 16'h7C00);
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         wr(ADDR_HARDWARE_CONFIG, {1'b0, v[8:6], 2'b00, v[3:2], 2'b00});
         wr(ADDR_INPUT_AND_DRIVER_CONFIG, {6'h00, v[3:0]});
         rd(ADDR_INPUT_AND_DRIVER_CONFIG, r);
         check(r, {1'b0, ADDR_INPUT_AND_DRIVER_CONFIG, 6'h00, v[3:0]});
         rd(ADDR_HARDWARE_CONFIG, r);
         check(r, {1'b0, ADDR_HARDWARE_CONFIG, 1'b0, v[8:6], 2'b00, v[3:2], 2'b10});
         check({13'h0000, input_drive_bit, lamp_type_bit}, {13'h0000, v[2], v[3:2]});
      end
      wr(ADDR_PCR, 10'h001);
      check({15'h0000, standby_out}, 16'h0000);
      wr(ADDR_PCR, 10'h000);
      for (int i = 0; i < 8; i++) begin
         v = rnd();
         in_pin = v[5:0];
         wr(ADDR_INPUT_AND_DRIVER_CONFIG, {6'h00, v[15:12]});
         wr(ADDR_OUT, {4'h0, v[11:6]});
         e = v[15] ? (v[5:0] & v[11:6]) : (v[5:0] | v[11:6]);
         check({10'h000, channel_on}, {10'h000, e});
      end
      pclk_en = 1'b1;
      v = rnd();
      dt = '{{1'b0, v[7:0] | 8'h01}, {1'b0, v[15:8] | 8'h01}, 9'h0FF,
             {1'b0, v[23:16] | 8'h01}, {1'b1, v[31:24]}, 9'h000};
      for (int k = 0; k < 6; k++) begin
         wr(ADDR_CHCR + 5'(k), {3'h0, (k == 1) ? v[2:0] : 3'h0, 2'h0, fq[k]});
         wr(ADDR_DCCR + 5'(k), {1'b0, dt[k]});
      end
      wr(ADDR_PCR, {6'h00, 1'b1, v[9:8], 1'b1});
      wr(ADDR_OUT, 10'h03F);
      for (int s = 0; s < 2; s++) begin
         wait_ticks((s == 0) ? 1088 : 64);
         on_cnt = '{default: 0};
         wait_ticks(1024);
         for (int k = 0; k < 6; k++) begin
            check(16'(on_cnt[k]), 16'((s == 1 && k == 1) ? 0 : 4 * eff(dt[s == 1 ? 0 : k])));
            if (s == 0 && k < 4) check(16'(per[k]), 16'(256 << (fq[k] - 2'h1)));
         end
         if (s == 0) check({8'h00, 8'(rise_at[1] - rise_at[0])}, {8'h00, v[2:0], 5'h00});
         wr(ADDR_PCR, {6'h00, 1'b0, v[9:8], 1'b0});
         wr(ADDR_PCR, {6'h00, 1'b0, v[9:8], 1'b1});
         wr(ADDR_OUT, 10'h03D);
      end
      pclk_en = 1'b0;
      repeat (1000) @(negedge core_clk);
      wr(ADDR_OUT, 10'h000);
      check(resp, 16'h0800);
      pclk_en = 1'b1;
      wr(ADDR_OUT, 10'h000);
      check(resp, 16'h0800);
      wr(ADDR_OUT, 10'h000);
      check(resp, 16'h0000);
      end_sim();
   end
endmodule : tb
bind apg_top apg_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.core_clk(core_clk), .rst(rst),
   .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
   .pclk_pin(pclk_pin), .in_pin(in_pin), .channel_on(channel_on),
   .lamp_type_bit(lamp_type_bit), .input_drive_bit(input_drive_bit),
   .ext_driver_diag_out0(ext_driver_diag_out0), .ext_driver_diag_out1(ext_driver_diag_out1),
   .standby_out(standby_out));
`default_nettype wire
